// ### design/ifp_intc.sv
/*
 interrupt flag, enable and priority block with halt and sleep standby.
 assumes event inputs synchronous to mclk, a 32-bit AXI4-Lite master,
 and a cpu core that compares the request level against its own mask.
*/
`timescale 1ns/1ps
// Function
// - fifteen sources in six systems
// - one enable bit per source flag
// - one shared priority per system
// - request needs flag, enable, level above mask
// - timer underflows set high bits seven, six
// - single key mismatch sets high bit five
// - key group halves set bits four, three
// - serial error, receive, transmit set bits two-zero
// - stopwatch falling edges set low bits six-four
// - clock timer rising edges set low bits three-zero
// - flags stay set until one written
// - reset clears all flags
// - enables readable, cleared at reset
// - halt ends on reset or any request
// - sleep ends on reset or key interrupt
// - sleep wake waits 8192 oscillator periods
// - priority field encodes level directly
// - reset sets all priorities to zero
// - fixed order breaks equal level ties
module ifp_intc (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ifp_pkg::ifp_events_t events,
    input wire logic single_key_input,
    input wire logic [3:0] upper_key_inputs,
    input wire logic [3:0] lower_key_inputs,
    input wire logic single_key_compare_bit,
    input wire logic [3:0] upper_key_compare_bits,
    input wire logic [3:0] lower_key_compare_bits,
    input wire logic cpu_mask_bit_low,
    input wire logic cpu_mask_bit_high,
    input wire logic low_osc_tick,
    output ifp_pkg::ifp_req_t cpu_req,
    output logic cpu_run,
    output logic periph_run
);
    logic [7:0] flags_low;
    logic [7:0] flags_high;
    logic [7:0] enable_low;
    logic [7:0] enable_high;
    logic [7:0] prio_low;
    logic [7:0] prio_high;
    logic [7:0] set_low;
    logic [7:0] set_high;
    logic [7:0] clr_low;
    logic [7:0] clr_high;
    logic [11:0] edge_prev;
    logic skey_prev;
    logic [3:0] ukey_prev;
    logic [3:0] lkey_prev;
    logic skey_mis;
    logic [3:0] ukey_mis;
    logic [3:0] lkey_mis;
    logic [1:0] sys_level [ifp_pkg::NUM_SYS];
    logic [ifp_pkg::NUM_SYS-1:0] sys_pend;
    logic [1:0] mask_level;
    ifp_pkg::ifp_req_t next_req;
    ifp_pkg::ifp_state_t state;
    ifp_pkg::ifp_state_t next_state;
    logic aw_held;
    logic w_held;
    logic [17:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [15:0] wr_idx;
    logic [15:0] rd_idx;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic wake_start;
    logic wake_busy;
    logic wake_done;
    logic key_req;
    logic standby_halt;
    logic standby_sleep;
    logic [11:0] ev_vec;
    logic [11:0] ev_edge;

    // previous samples for edge and mismatch change detection
    // reset loads the live event levels so no false or missed edge follows release
    assign ev_vec = events;
    always_ff @(posedge mclk) begin
        if (reset) begin
            edge_prev <= ev_vec;
            skey_prev <= 1'b0;
            ukey_prev <= 4'h0;
            lkey_prev <= 4'h0;
        end else begin
            edge_prev <= ev_vec;
            skey_prev <= skey_mis;
            ukey_prev <= ukey_mis;
            lkey_prev <= lkey_mis;
        end
    end

    // stopwatch bits fall-edge, clock timer bits rise-edge, others are pulses
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_edge
            if (gi >= 4 && gi <= 6) begin : g_fall
                assign ev_edge[gi] = edge_prev[gi] && !ev_vec[gi];
            end else if (gi < 4) begin : g_rise
                assign ev_edge[gi] = !edge_prev[gi] && ev_vec[gi];
            end else begin : g_pulse
                assign ev_edge[gi] = ev_vec[gi];
            end
        end
    endgenerate

    // key mismatch against the compare bits, flag on the onset
    assign skey_mis = single_key_input != single_key_compare_bit;
    assign ukey_mis = upper_key_inputs ^ upper_key_compare_bits;
    assign lkey_mis = lower_key_inputs ^ lower_key_compare_bits;

    // event to flag position mapping
    always_comb begin
        set_high = 8'h00;
        set_low = 8'h00;
        set_high[ifp_pkg::BIT_PT1] = ev_edge[11];
        set_high[ifp_pkg::BIT_PT0] = ev_edge[10];
        set_high[ifp_pkg::BIT_SKEY] = skey_mis && !skey_prev;
        set_high[ifp_pkg::BIT_KEYH] = |(ukey_mis & ~ukey_prev);
        set_high[ifp_pkg::BIT_KEYL] = |(lkey_mis & ~lkey_prev);
        set_high[ifp_pkg::BIT_SERR] = ev_edge[9];
        set_high[ifp_pkg::BIT_SREC] = ev_edge[8];
        set_high[ifp_pkg::BIT_STRA] = ev_edge[7];
        set_low[ifp_pkg::BIT_SW100] = ev_edge[6];
        set_low[ifp_pkg::BIT_SW10] = ev_edge[5];
        set_low[ifp_pkg::BIT_SW1] = ev_edge[4];
        set_low[ifp_pkg::BIT_TM32] = ev_edge[3];
        set_low[ifp_pkg::BIT_TM8] = ev_edge[2];
        set_low[ifp_pkg::BIT_TM2] = ev_edge[1];
        set_low[ifp_pkg::BIT_TM1] = ev_edge[0];
    end

    // write channel capture, address and data in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end
    assign wr_fire = aw_held && w_held;
    assign wr_idx = aw_addr[17:2];
    assign wr_hit = wr_idx >= ifp_pkg::PRIO_LOW_IDX && wr_idx <= ifp_pkg::IRQ_STATUS_IDX;

    // write response one cycle after both halves are held
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ifp_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? ifp_pkg::RESP_OKAY : ifp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // write-one-to-clear strobes, byte lane zero only
    assign clr_low = (wr_fire && w_strb[0] && wr_idx == ifp_pkg::FLAG_LOW_IDX) ? w_data[7:0] : 8'h00;
    assign clr_high = (wr_fire && w_strb[0] && wr_idx == ifp_pkg::FLAG_HIGH_IDX) ? w_data[7:0] : 8'h00;

    // sticky flags: set wins over clear, zero write keeps the flag
    always_ff @(posedge mclk) begin
        if (reset) begin
            flags_low <= ifp_pkg::REG_RESET;
            flags_high <= ifp_pkg::REG_RESET;
        end else if (!state[2]) begin
            flags_low <= ((flags_low & ~clr_low) | set_low) & ifp_pkg::LOW_FLAG_MASK;
            flags_high <= (flags_high & ~clr_high) | set_high;
        end else begin
            flags_high[ifp_pkg::BIT_SKEY] <= flags_high[ifp_pkg::BIT_SKEY] | set_high[ifp_pkg::BIT_SKEY];
            flags_high[ifp_pkg::BIT_KEYH] <= flags_high[ifp_pkg::BIT_KEYH] | set_high[ifp_pkg::BIT_KEYH];
            flags_high[ifp_pkg::BIT_KEYL] <= flags_high[ifp_pkg::BIT_KEYL] | set_high[ifp_pkg::BIT_KEYL];
        end
    end

    // enable and priority registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            enable_low <= ifp_pkg::REG_RESET;
            enable_high <= ifp_pkg::REG_RESET;
            prio_low <= ifp_pkg::REG_RESET;
            prio_high <= ifp_pkg::REG_RESET;
        end else if (wr_fire && w_strb[0]) begin
            case (wr_idx)
                ifp_pkg::ENABLE_LOW_IDX: enable_low <= w_data[7:0] & ifp_pkg::LOW_FLAG_MASK;
                ifp_pkg::ENABLE_HIGH_IDX: enable_high <= w_data[7:0];
                ifp_pkg::PRIO_LOW_IDX: prio_low <= w_data[7:0];
                ifp_pkg::PRIO_HIGH_IDX: prio_high <= {4'h0, w_data[3:0]};
                default: ;
            endcase
        end
    end

    // per-system level and pending terms
    assign sys_level[ifp_pkg::SYS_PTIMER] = prio_high[ifp_pkg::PRI_PT_POS +: 2];
    assign sys_level[ifp_pkg::SYS_SKEY] = prio_high[ifp_pkg::PRI_SKEY_POS +: 2];
    assign sys_level[ifp_pkg::SYS_GKEY] = prio_low[ifp_pkg::PRI_GKEY_POS +: 2];
    assign sys_level[ifp_pkg::SYS_SERIAL] = prio_low[ifp_pkg::PRI_SER_POS +: 2];
    assign sys_level[ifp_pkg::SYS_STOPWATCH] = prio_low[ifp_pkg::PRI_SW_POS +: 2];
    assign sys_level[ifp_pkg::SYS_CLOCKTIMER] = prio_low[ifp_pkg::PRI_TM_POS +: 2];
    assign sys_pend[ifp_pkg::SYS_PTIMER] = |(flags_high[7:6] & enable_high[7:6]);
    assign sys_pend[ifp_pkg::SYS_SKEY] = flags_high[5] & enable_high[5];
    assign sys_pend[ifp_pkg::SYS_GKEY] = |(flags_high[4:3] & enable_high[4:3]);
    assign sys_pend[ifp_pkg::SYS_SERIAL] = |(flags_high[2:0] & enable_high[2:0]);
    assign sys_pend[ifp_pkg::SYS_STOPWATCH] = |(flags_low[6:4] & enable_low[6:4]);
    assign sys_pend[ifp_pkg::SYS_CLOCKTIMER] = |(flags_low[3:0] & enable_low[3:0]);
    assign mask_level = {cpu_mask_bit_high, cpu_mask_bit_low};

    // highest level wins, lower system index breaks ties
    always_comb begin
        next_req = '0;
        for (int s = ifp_pkg::NUM_SYS - 1; s >= 0; s--) begin
            if (sys_pend[s] && sys_level[s] > mask_level && sys_level[s] >= next_req.level) begin
                next_req.valid = 1'b1;
                next_req.level = sys_level[s];
                next_req.system = 3'(s);
            end
        end
    end

    // request register held for the core to sample at fetch
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_req <= '0;
        end else begin
            cpu_req <= next_req;
        end
    end

    // standby requests from software, one-cycle commands
    assign standby_halt = wr_fire && w_strb[0] && wr_idx == ifp_pkg::STANDBY_CTRL_IDX
                          && w_data[ifp_pkg::CTRL_HALT];
    assign standby_sleep = wr_fire && w_strb[0] && wr_idx == ifp_pkg::STANDBY_CTRL_IDX
                           && w_data[ifp_pkg::CTRL_SLEEP];
    assign key_req = |(set_high[5:3] & enable_high[5:3]) || |(flags_high[5:3] & enable_high[5:3]);
    assign wake_start = state[2] && key_req && !wake_busy && !wake_done; // no restart on the wake edge

    // standby state machine
    always_comb begin
        next_state = state;
        case (state)
            ifp_pkg::IFP_RUN: begin
                if (standby_sleep) begin
                    next_state = ifp_pkg::IFP_SLEEP;
                end else if (standby_halt) begin
                    next_state = ifp_pkg::IFP_HALT;
                end
            end
            ifp_pkg::IFP_HALT: begin
                if (next_req.valid) begin
                    next_state = ifp_pkg::IFP_RUN;
                end
            end
            ifp_pkg::IFP_SLEEP: begin
                if (wake_done) begin
                    next_state = ifp_pkg::IFP_RUN;
                end
            end
            default: next_state = ifp_pkg::IFP_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ifp_pkg::IFP_RUN;
        end else begin
            state <= next_state;
        end
    end
    assign cpu_run = state[0];
    assign periph_run = !state[2];

    ifp_wake_timer #(
        .PERIODS(ifp_pkg::WAKE_OSC_PERIODS)
    ) u_wake (
        .mclk(mclk),
        .reset(reset),
        .start(wake_start),
        .osc_tick(low_osc_tick),
        .busy(wake_busy),
        .done(wake_done)
    );

    // read path, answer one cycle after address accepted
    assign rd_idx = s_axi_araddr[17:2];
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (rd_idx)
            ifp_pkg::PRIO_LOW_IDX: rd_word[7:0] = prio_low;
            ifp_pkg::PRIO_HIGH_IDX: rd_word[7:0] = prio_high;
            ifp_pkg::ENABLE_LOW_IDX: rd_word[7:0] = enable_low;
            ifp_pkg::ENABLE_HIGH_IDX: rd_word[7:0] = enable_high;
            ifp_pkg::FLAG_LOW_IDX: rd_word[7:0] = flags_low;
            ifp_pkg::FLAG_HIGH_IDX: rd_word[7:0] = flags_high;
            ifp_pkg::STANDBY_CTRL_IDX: rd_word[2:0] = state;
            ifp_pkg::IRQ_STATUS_IDX: rd_word[5:0] = {next_req.valid, next_req.level, next_req.system};
            default: rd_hit = 1'b0;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ifp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? ifp_pkg::RESP_OKAY : ifp_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_flag_set_wins: assert property (@(posedge mclk) disable iff (reset)
        (set_high[ifp_pkg::BIT_PT1] && !state[2]) |=> flags_high[ifp_pkg::BIT_PT1])
        else $error("flag event lost");
    a_flag_clear_one: assert property (@(posedge mclk) disable iff (reset)
        (clr_low[0] && !set_low[0] && !state[2]) |=> !flags_low[0])
        else $error("flag not cleared by one");
    a_req_above_mask: assert property (@(posedge mclk) disable iff (reset)
        cpu_req.valid |-> $past(next_req.level) > $past(mask_level))
        else $error("request at or below mask");
    a_level_zero_quiet: assert property (@(posedge mclk) disable iff (reset)
        (prio_low == 8'h00 && prio_high == 8'h00) |=> !cpu_req.valid)
        else $error("level zero raised request");
    a_halt_exit: assert property (@(posedge mclk) disable iff (reset)
        (state == ifp_pkg::IFP_HALT && next_req.valid) |=> state == ifp_pkg::IFP_RUN)
        else $error("halt not left on request");
    a_sleep_holds: assert property (@(posedge mclk) disable iff (reset)
        (state == ifp_pkg::IFP_SLEEP && !wake_done) |=> state == ifp_pkg::IFP_SLEEP)
        else $error("sleep left without wake");
    a_tm_rise: assert property (@(posedge mclk) disable iff (reset)
        ($rose(events.tm_1hz) && !state[2]) |=> flags_low[ifp_pkg::BIT_TM1])
        else $error("clock timer edge missed");
    a_sw_fall: assert property (@(posedge mclk) disable iff (reset)
        ($fell(events.sw_1hz) && !state[2]) |=> flags_low[ifp_pkg::BIT_SW1])
        else $error("stopwatch edge missed");
endmodule // ifp_intc

// ### inc/ifp_pkg.sv
/*
 package for the interrupt flag, enable and priority block: register map,
 field positions, reset values, system indices and wake timing.
 assumes 32-bit AXI4-Lite access, one register per aligned word.
*/
package ifp_pkg;
    // printed offsets run in steps of one, not four: they are indices, byte address is index times four
    localparam logic [15:0] PRIO_LOW_IDX = 16'hFF20;
    localparam logic [15:0] PRIO_HIGH_IDX = 16'hFF21;
    localparam logic [15:0] ENABLE_LOW_IDX = 16'hFF22;
    localparam logic [15:0] ENABLE_HIGH_IDX = 16'hFF23;
    localparam logic [15:0] FLAG_LOW_IDX = 16'hFF24;
    localparam logic [15:0] FLAG_HIGH_IDX = 16'hFF25;
    localparam logic [15:0] STANDBY_CTRL_IDX = 16'hFF26;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'hFF27;
    localparam int ADDR_W = 18;
    localparam int NUM_SRC = 15;
    localparam int NUM_SYS = 6;
    // system indices, lower index wins at equal level
    localparam int SYS_PTIMER = 0;
    localparam int SYS_SKEY = 1;
    localparam int SYS_GKEY = 2;
    localparam int SYS_SERIAL = 3;
    localparam int SYS_STOPWATCH = 4;
    localparam int SYS_CLOCKTIMER = 5;
    // flag bit positions inside the low and high flag registers
    localparam int BIT_PT1 = 7;
    localparam int BIT_PT0 = 6;
    localparam int BIT_SKEY = 5;
    localparam int BIT_KEYH = 4;
    localparam int BIT_KEYL = 3;
    localparam int BIT_SERR = 2;
    localparam int BIT_SREC = 1;
    localparam int BIT_STRA = 0;
    localparam int BIT_SW100 = 6;
    localparam int BIT_SW10 = 5;
    localparam int BIT_SW1 = 4;
    localparam int BIT_TM32 = 3;
    localparam int BIT_TM8 = 2;
    localparam int BIT_TM2 = 1;
    localparam int BIT_TM1 = 0;
    // priority field positions
    localparam int PRI_PT_POS = 2;
    localparam int PRI_SKEY_POS = 0;
    localparam int PRI_GKEY_POS = 6;
    localparam int PRI_SER_POS = 4;
    localparam int PRI_SW_POS = 2;
    localparam int PRI_TM_POS = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LOW_FLAG_MASK = 8'h7F;
    // standby control bits
    localparam int CTRL_HALT = 0;
    localparam int CTRL_SLEEP = 1;
    // wake wait in low-speed oscillator periods
    localparam int WAKE_OSC_PERIODS = 8192;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        IFP_RUN = 3'b001,
        IFP_HALT = 3'b010,
        IFP_SLEEP = 3'b100
    } ifp_state_t;

    // request toward the cpu core
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [2:0] system;
    } ifp_req_t;

    // peripheral event inputs, one pulse or level per source
    typedef struct packed {
        logic pt1_underflow;
        logic pt0_underflow;
        logic serial_rx_error;
        logic serial_rx_done;
        logic serial_tx_done;
        logic sw_100hz;
        logic sw_10hz;
        logic sw_1hz;
        logic tm_32hz;
        logic tm_8hz;
        logic tm_2hz;
        logic tm_1hz;
    } ifp_events_t;
endpackage

// ### design/ifp_wake_timer.sv
/*
 wake wait counter: counts rising edges of the low-speed oscillator tick
 after a sleep wake-up and reports done. assumes osc_tick is a one-cycle
 pulse synchronous to mclk.
*/
`timescale 1ns/1ps
module ifp_wake_timer #(
    parameter int PERIODS = ifp_pkg::WAKE_OSC_PERIODS
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    input wire logic osc_tick,
    output logic busy,
    output logic done
);
    logic [13:0] count;

    // counts oscillator ticks while busy
    always_ff @(posedge mclk) begin
        if (reset) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                count <= '0;
            end else if (busy && osc_tick) begin
                if (count == 14'(PERIODS - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + 14'h0001;
                end
            end
        end
    end

    a_wait_length: assert property (@(posedge mclk) disable iff (reset)
        done |-> $past(count) == 14'(PERIODS - 1))
        else $error("wake wait ended early");
endmodule // ifp_wake_timer

// ### verification/ifp_cpu_model.sv
/*
 cpu core stand-in: drives the mask level and samples requests at fetch.
 assumes one mclk domain and a registered cpu_req.
*/
`timescale 1ns/1ps
module ifp_cpu_model (
    input wire logic mclk,
    input wire logic reset,
    input wire ifp_pkg::ifp_req_t cpu_req,
    input wire logic [1:0] mask_level,
    output logic cpu_mask_bit_low,
    output logic cpu_mask_bit_high,
    output logic accepted
);
    logic [1:0] fetch_cnt;
    // mask level as software left it
    assign {cpu_mask_bit_high, cpu_mask_bit_low} = mask_level;
    // request sampled on every fourth cycle, the opcode fetch
    always_ff @(posedge mclk) begin
        if (reset) begin
            fetch_cnt <= 2'h0;
            accepted <= 1'b0;
        end else begin
            fetch_cnt <= fetch_cnt + 2'h1;
            if (fetch_cnt == 2'h0 && cpu_req.valid && cpu_req.level > mask_level) begin
                accepted <= 1'b1;
            end
        end
    end
endmodule // ifp_cpu_model

// ### verification/test_ifp_intc.sv
/*
 testbench for the interrupt block: axi-lite register calls, event stimulus.
 assumes the cpu model beside it and a 200 MHz mclk.
*/
`timescale 1ns/1ps
module test_ifp_intc;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [17:0] s_axi_awaddr = 18'h0;
    logic [17:0] s_axi_araddr = 18'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    ifp_pkg::ifp_events_t events = 12'h070;
    logic single_key_input = 1'b0, single_key_compare_bit = 1'b0, low_osc_tick = 1'b0;
    logic [3:0] upper_key_inputs = 4'h0, lower_key_inputs = 4'h0;
    logic [3:0] upper_key_compare_bits = 4'h0, lower_key_compare_bits = 4'h0;
    logic [1:0] mask_level = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cpu_mask_bit_low, cpu_mask_bit_high, cpu_run, periph_run, accepted;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [31:0] s_axi_rdata, rd_data;
    ifp_pkg::ifp_req_t cpu_req;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    ifp_intc u_ifp_intc (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events, .single_key_input,
        .upper_key_inputs, .lower_key_inputs, .single_key_compare_bit, .upper_key_compare_bits,
        .lower_key_compare_bits, .cpu_mask_bit_low, .cpu_mask_bit_high, .low_osc_tick, .cpu_req, .cpu_run,
        .periph_run);
    ifp_cpu_model u_ifp_cpu_model (.mclk, .reset, .cpu_req, .mask_level, .cpu_mask_bit_low, .cpu_mask_bit_high,
        .accepted);
    // clock and hang guard
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    function automatic logic [17:0] ad(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction
    // readies sampled at the falling edge, stable until the next rising edge
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic ah, wh, bh;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(negedge mclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            wr_resp = s_axi_bresp;
            @(posedge mclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [17:0] a);
        logic ah, rh;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge mclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            @(posedge mclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(ad(ifp_pkg::PRIO_LOW_IDX + 16'(i)));
            chk(rd_data, 32'h0);
        end
        $display("test 1 done");
        wr(ad(ifp_pkg::ENABLE_HIGH_IDX), 8'hA5);
        rd(ad(ifp_pkg::ENABLE_HIGH_IDX));
        chk(rd_data, 32'hA5);
        wr(ad(ifp_pkg::ENABLE_HIGH_IDX), 8'h00);
        $display("test 2 done");
        // every source fires once: pulses, falling and rising edges, key mismatches
        events <= 12'hF8F;
        single_key_input <= 1'b1;
        upper_key_inputs <= 4'h8;
        lower_key_inputs <= 4'h2;
        @(posedge mclk);
        events <= 12'h00F;
        rd(ad(ifp_pkg::FLAG_LOW_IDX));
        chk(rd_data, 32'h7F);
        rd(ad(ifp_pkg::FLAG_HIGH_IDX));
        chk(rd_data, 32'hFF);
        wr(ad(ifp_pkg::FLAG_HIGH_IDX), 8'h00);
        rd(ad(ifp_pkg::FLAG_HIGH_IDX));
        chk(rd_data, 32'hFF);
        wr(ad(ifp_pkg::FLAG_HIGH_IDX), 8'h81);
        rd(ad(ifp_pkg::FLAG_HIGH_IDX));
        chk(rd_data, 32'h7E);
        $display("test 3 done");
        // stopwatch and clock timer both at level 2, mask 1
        mask_level <= 2'h1;
        wr(ad(ifp_pkg::PRIO_LOW_IDX), 8'h0A);
        wr(ad(ifp_pkg::ENABLE_LOW_IDX), 8'h11);
        repeat (8) @(posedge mclk);
        chk({26'h0, cpu_req}, {26'h0, 6'b1_10_100});
        chk({31'h0, accepted}, 32'h1);
        rd(ad(ifp_pkg::IRQ_STATUS_IDX));
        chk(rd_data, 32'h34);
        mask_level <= 2'h2;
        repeat (3) @(posedge mclk);
        chk({31'h0, cpu_req.valid}, 32'h0);
        wr(ad(ifp_pkg::STANDBY_CTRL_IDX), 8'h01);
        repeat (3) @(posedge mclk);
        chk({30'h0, cpu_run, periph_run}, 32'h1);
        mask_level <= 2'h1;
        repeat (4) @(posedge mclk);
        chk({31'h0, cpu_run}, 32'h1);
        wr(ad(ifp_pkg::FLAG_LOW_IDX), 8'h10);
        repeat (3) @(posedge mclk);
        chk({26'h0, cpu_req}, {26'h0, 6'b1_10_101});
        wr(ad(ifp_pkg::FLAG_LOW_IDX), 8'h01);
        repeat (3) @(posedge mclk);
        chk({31'h0, cpu_req.valid}, 32'h0);
        $display("test 4 done");
        // sleep, single key wake, then the oscillator wait
        single_key_input <= 1'b0;
        wr(ad(ifp_pkg::ENABLE_HIGH_IDX), 8'h20);
        wr(ad(ifp_pkg::FLAG_HIGH_IDX), 8'h38);
        wr(ad(ifp_pkg::STANDBY_CTRL_IDX), 8'h02);
        repeat (2) @(posedge mclk);
        chk({30'h0, cpu_run, periph_run}, 32'h0);
        single_key_input <= 1'b1;
        @(posedge mclk);
        repeat (8191) begin
            low_osc_tick <= 1'b1;
            @(posedge mclk);
            low_osc_tick <= 1'b0;
            @(posedge mclk);
        end
        chk({30'h0, cpu_run, periph_run}, 32'h0);
        low_osc_tick <= 1'b1;
        @(posedge mclk);
        low_osc_tick <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({30'h0, cpu_run, periph_run}, 32'h3);
        rd(ad(ifp_pkg::STANDBY_CTRL_IDX));
        chk(rd_data, 32'h1);
        $display("test 5 done");
        rd(18'h00000);
        chk(rd_data, 32'h0);
        chk({30'h0, rd_resp}, {30'h0, ifp_pkg::RESP_SLVERR});
        wr(18'h00000, 8'h00);
        chk({30'h0, wr_resp}, {30'h0, ifp_pkg::RESP_SLVERR});
        $display("test 6 done");
        final_report();
    end
endmodule // test_ifp_intc
